// ===== inc/pcd_defines.svh
/*
  Offsets, field positions, reset values and clock figures for the
  multiplier and CPU clock divider control block.
  Assumes inclusion by bare name from files that also import pcd_pkg.
*/
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

`define PCD_CLK_PERIOD_NS 25

// ============================================================
// Register offsets (byte addresses)
`define PCD_OFF_OSC_CTRL 8'h00
`define PCD_OFF_OSC_TUNE 8'h04
`define PCD_OFF_STATUS 8'h08
`define PCD_OFF_CONFIG 8'h0C
`define PCD_OFF_SYS_KHZ 8'h10
`define PCD_OFF_CPU_KHZ 8'h14

// ============================================================
// Field positions
`define PCD_SCS_LSB 0
`define PCD_INTERNAL_OSC_FREQ_SELECT_LSB 4
`define PCD_MULT_SOFTWARE_ENABLE_BIT 6
`define PCD_OSCILLATOR_SOURCE_CONFIG_LSB 0
`define PCD_FORCE_BIT 4
`define PCD_CPU_CLOCK_DIV_SELECT_LSB 3

// ============================================================
// Reset values and codes
`define PCD_SCS_RESET 2'h0
`define PCD_INTERNAL_OSC_FREQ_SELECT_RESET 3'h3
`define PCD_INTERNAL_OSC_FREQ_SELECT_8MHZ 3'h6
`define PCD_OSCILLATOR_SOURCE_CONFIG_INT_A 4'h8
`define PCD_OSCILLATOR_SOURCE_CONFIG_INT_B 4'h9
`define PCD_MULT_FACTOR 20'h00004
`define PCD_SECONDARY_KHZ 20'h00020
`define PCD_EXT_OSC_KHZ 20'h02EE0

`endif

// ===== inc/pcd_pkg.sv
/*
  Types shared by the clock control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pcd_pkg;
  typedef enum logic [1:0] {
    PCD_SRC_PRIMARY,
    PCD_SRC_SECONDARY,
    PCD_SRC_INTERNAL
  } pcd_src_t;
  typedef logic [19:0] pcd_khz_t;
  typedef logic [1:0] pcd_ratio_t;
endpackage

// ===== inc/pcd_div_if.sv
/*
  Link between the control block and its CPU clock divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface pcd_div_if;
  import pcd_pkg::*;
  logic src_rise;
  logic src_level;
  pcd_ratio_t ratio;
  logic div_clk;
  logic div_tick;
  modport ctrl (output src_rise, output src_level, output ratio, input div_clk, input div_tick);
  modport div (input src_rise, input src_level, input ratio, output div_clk, output div_tick);
endinterface

// ===== logic/pcd_cpu_div.sv
/*
  CPU clock divider: divides the configured source by one to four.
  Assumes source edges arrive already synchronised as one-cycle pulses.
*/
`timescale 1ns/100ps
module pcd_cpu_div (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  pcd_div_if.div dv
);
  import pcd_pkg::*;
  logic [1:0] cnt;
  logic [1:0] half;
  logic div_clk;
  logic div_tick;

  // Number of source edges the output stays high
  assign half = dv.ratio[1] ? 2'h2 : 2'h1;

  // ============================================================
  // Edge counter, moves only on source edges
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cnt <= 2'h0;
    end else if (dv.src_rise) begin
      cnt <= (cnt >= dv.ratio) ? 2'h0 : cnt + 2'h1;
    end
  end

  // ============================================================
  // Registered output, glitch free by construction
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      div_clk <= 1'b0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= dv.src_rise && (cnt >= dv.ratio);
      if (dv.ratio == 2'h0) begin
        div_clk <= dv.src_level;
      end else if (dv.src_rise) begin
        // Ratio two (divide by three) is high two edges, low one: duty is traded for simplicity
        div_clk <= (((cnt >= dv.ratio) ? 2'h0 : cnt + 2'h1) < half);
      end
    end
  end

  assign dv.div_clk = div_clk;
  assign dv.div_tick = div_tick;
endmodule

// ===== logic/pcd_top.sv
/*
  Clock control: times-four multiplier enable, system clock source and
  frequency tracking, CPU clock divider, AXI4-Lite register slave.
  Assumes configuration straps are stable while SRST_I is high and the
  configured oscillator arrives on SRC_CLK_I well below MCLK_I / 2.
*/
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pcd_defines.svh"
module pcd_top (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] CFG_HIGH_I,
  input wire logic [7:0] CFG_LOW_I,
  input wire logic SRC_CLK_I,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic MULT_ENABLED_O,
  output pcd_pkg::pcd_src_t SYS_SRC_O,
  output pcd_pkg::pcd_khz_t SYS_CLK_KHZ_O,
  output pcd_pkg::pcd_khz_t CPU_CLK_KHZ_O,
  output logic CPU_CLK_O,
  output logic CPU_TICK_O
);
  import pcd_pkg::*;

  logic [7:0] cfg_h_s1;
  logic [7:0] cfg_h_s2;
  logic [7:0] cfg_l_s1;
  logic [7:0] cfg_l_s2;
  logic [7:0] config_word_one_high;
  logic [7:0] config_word_one_low;
  logic src_s1;
  logic src_s2;
  logic src_s3;
  logic [1:0] system_clock_select;
  logic [2:0] internal_osc_freq_select;
  logic mult_software_enable;
  logic mult_on;
  logic [3:0] oscillator_source_config;
  logic mult_config_force_enable;
  logic oscillator_source_config_internal;
  pcd_khz_t internal_oscillator_khz;
  pcd_khz_t primary_khz;
  pcd_khz_t next_sys_khz;
  pcd_khz_t next_cpu_khz;
  pcd_src_t next_src;
  logic wr_go;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic [1:0] next_scs;
  logic [2:0] next_internal_osc_freq_select;
  logic [31:0] rd_word;
  logic rd_hit;

  pcd_div_if dv ();

  // ============================================================
  // Synchronisers and strap capture
  always_ff @(posedge MCLK_I) begin
    cfg_h_s1 <= CFG_HIGH_I;
    cfg_h_s2 <= cfg_h_s1;
    cfg_l_s1 <= CFG_LOW_I;
    cfg_l_s2 <= cfg_l_s1;
    src_s1 <= SRC_CLK_I;
    src_s2 <= src_s1;
    src_s3 <= src_s2;
  end

  // Configuration words are only taken while reset is held
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      config_word_one_high <= cfg_h_s2;
      config_word_one_low <= cfg_l_s2;
    end
  end

  assign oscillator_source_config = config_word_one_high[`PCD_OSCILLATOR_SOURCE_CONFIG_LSB +: 4];
  assign mult_config_force_enable = config_word_one_high[`PCD_FORCE_BIT];
  assign oscillator_source_config_internal = (oscillator_source_config == `PCD_OSCILLATOR_SOURCE_CONFIG_INT_A) ||
                         (oscillator_source_config == `PCD_OSCILLATOR_SOURCE_CONFIG_INT_B);

  // ============================================================
  // Multiplier enable
  assign mult_on = mult_config_force_enable | mult_software_enable;

  // ============================================================
  // Frequency tracking
  always_comb begin
    unique case (internal_osc_freq_select)
      3'h0: internal_oscillator_khz = 20'h0001F;
      3'h1: internal_oscillator_khz = 20'h000FA;
      3'h2: internal_oscillator_khz = 20'h001F4;
      3'h3: internal_oscillator_khz = 20'h003E8;
      3'h4: internal_oscillator_khz = 20'h007D0;
      3'h5: internal_oscillator_khz = 20'h00FA0;
      3'h6: internal_oscillator_khz = 20'h01F40;
      3'h7: internal_oscillator_khz = 20'h03E80;
    endcase
  end

  always_comb begin
    primary_khz = oscillator_source_config_internal ? internal_oscillator_khz : `PCD_EXT_OSC_KHZ;
    if (mult_on) begin
      primary_khz = 20'(primary_khz * `PCD_MULT_FACTOR);
    end
    next_src = PCD_SRC_PRIMARY;
    next_sys_khz = primary_khz;
    if (system_clock_select == 2'h1) begin
      next_src = PCD_SRC_SECONDARY;
      next_sys_khz = `PCD_SECONDARY_KHZ;
    end else if (system_clock_select[1]) begin
      next_src = PCD_SRC_INTERNAL;
      next_sys_khz = internal_oscillator_khz;
    end
    // Divider sees the configured source only
    unique case (config_word_one_low[`PCD_CPU_CLOCK_DIV_SELECT_LSB +: 2])
      2'h0: next_cpu_khz = primary_khz;
      2'h1: next_cpu_khz = primary_khz / 20'h00002;
      2'h2: next_cpu_khz = primary_khz / 20'h00003;
      2'h3: next_cpu_khz = primary_khz / 20'h00004;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      MULT_ENABLED_O <= 1'b0;
      SYS_SRC_O <= PCD_SRC_PRIMARY;
      SYS_CLK_KHZ_O <= 20'h00000;
      CPU_CLK_KHZ_O <= 20'h00000;
    end else begin
      MULT_ENABLED_O <= mult_on;
      SYS_SRC_O <= next_src;
      SYS_CLK_KHZ_O <= next_sys_khz;
      CPU_CLK_KHZ_O <= next_cpu_khz;
    end
  end

  // ============================================================
  // CPU clock divider
  assign dv.src_rise = src_s2 & ~src_s3;
  assign dv.src_level = src_s2;
  assign dv.ratio = config_word_one_low[`PCD_CPU_CLOCK_DIV_SELECT_LSB +: 2];
  assign CPU_CLK_O = dv.div_clk;
  assign CPU_TICK_O = dv.div_tick;

  pcd_cpu_div u_div (
    .MCLK_I(MCLK_I),
    .SRST_I(SRST_I),
    .dv(dv)
  );

  // ============================================================
  // AXI4-Lite write path: address and data taken together
  assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign wr_off = S_AXI_AWADDR[7:0];
  assign next_scs = S_AXI_WDATA[`PCD_SCS_LSB +: 2];
  assign next_internal_osc_freq_select = S_AXI_WDATA[`PCD_INTERNAL_OSC_FREQ_SELECT_LSB +: 3];

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      system_clock_select <= `PCD_SCS_RESET;
      internal_osc_freq_select <= `PCD_INTERNAL_OSC_FREQ_SELECT_RESET;
      mult_software_enable <= 1'b0;
    end else if (wr_go && S_AXI_WSTRB[0] && S_AXI_AWADDR[31:8] == 24'h000000) begin
      if (wr_off == `PCD_OFF_OSC_CTRL) begin
        // Plain unmultiplied 8 MHz is refused while forced on
        if (!(mult_config_force_enable && next_scs[1] &&
              next_internal_osc_freq_select == `PCD_INTERNAL_OSC_FREQ_SELECT_8MHZ)) begin
          system_clock_select <= next_scs;
          internal_osc_freq_select <= next_internal_osc_freq_select;
        end
      end
      if (wr_off == `PCD_OFF_OSC_TUNE) begin
        mult_software_enable <= S_AXI_WDATA[`PCD_MULT_SOFTWARE_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (S_AXI_AWADDR[31:8] == 24'h000000 &&
                      (wr_off == `PCD_OFF_OSC_CTRL || wr_off == `PCD_OFF_OSC_TUNE))
                     ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ============================================================
  // AXI4-Lite read path
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign rd_off = S_AXI_ARADDR[7:0];

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = (S_AXI_ARADDR[31:8] == 24'h000000);
    unique case (rd_off)
      `PCD_OFF_OSC_CTRL: rd_word = {25'h0000000, internal_osc_freq_select, 2'h0,
                                    system_clock_select};
      `PCD_OFF_OSC_TUNE: rd_word = {25'h0000000, mult_software_enable, 6'h00};
      `PCD_OFF_STATUS: rd_word = {29'h00000000, SYS_SRC_O, MULT_ENABLED_O};
      `PCD_OFF_CONFIG: rd_word = {16'h0000, config_word_one_low, config_word_one_high};
      `PCD_OFF_SYS_KHZ: rd_word = {12'h000, SYS_CLK_KHZ_O};
      `PCD_OFF_CPU_KHZ: rd_word = {12'h000, CPU_CLK_KHZ_O};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'h0;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_hit ? rd_word : 32'h00000000;
      S_AXI_RRESP <= rd_hit ? 2'h0 : 2'h2;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule

// ===== testbench/pcd_top_chk.sv
/*
  Checker on the clock control top ports.
  Assumes straps change only while SRST_I is high.
*/
`timescale 1ns/100ps
`include "pcd_defines.svh"
module pcd_top_chk (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] CFG_HIGH_I,
  input wire logic [7:0] CFG_LOW_I,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_RVALID,
  input wire logic MULT_ENABLED_O,
  input wire pcd_pkg::pcd_src_t SYS_SRC_O,
  input wire pcd_pkg::pcd_khz_t SYS_CLK_KHZ_O,
  input wire pcd_pkg::pcd_khz_t CPU_CLK_KHZ_O,
  input wire logic CPU_TICK_O
);
  import pcd_pkg::*;
  // ==========
  // Settling after reset, straps need sync time
  logic [1:0] age;
  logic up;
  assign up = (age == 2'h3);
  always_ff @(posedge MCLK_I) age <= SRST_I ? 2'h0 : (up ? age : age + 2'h1);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  // ==========
  // Assertions
  chk_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID |=> S_AXI_BVALID)
    else $error("write answer missing");
  chk_read_answer: assert property (S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
    else $error("read answer missing");
  chk_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_force_on: assert property (up && CFG_HIGH_I[4] |-> MULT_ENABLED_O)
    else $error("forced multiplier off");
  chk_no_plain_8m: assert property (
    CFG_HIGH_I[4] |-> !(SYS_SRC_O == PCD_SRC_INTERNAL && SYS_CLK_KHZ_O == 20'h01F40))
    else $error("plain 8 MHz under force");
  chk_ext_times_four: assert property (
    up && SYS_SRC_O == PCD_SRC_PRIMARY && !(CFG_HIGH_I[3:0] inside {4'h8, 4'h9})
    |-> SYS_CLK_KHZ_O == (MULT_ENABLED_O ? 20'h0BB80 : `PCD_EXT_OSC_KHZ))
    else $error("external rate wrong");
  chk_direct_plain: assert property (SYS_SRC_O == PCD_SRC_INTERNAL |->
    SYS_CLK_KHZ_O inside {20'd31, 20'd250, 20'd500, 20'd1000, 20'd2000, 20'd4000,
    20'd8000, 20'd16000}) else $error("direct source multiplied");
  chk_cpu_ratio: assert property (up && SYS_SRC_O == PCD_SRC_PRIMARY |->
    CPU_CLK_KHZ_O == SYS_CLK_KHZ_O / ({18'h0, CFG_LOW_I[4:3]} + 20'h1))
    else $error("cpu divider ratio wrong");
  chk_tick_pulse: assert property (CPU_TICK_O |=> !CPU_TICK_O)
    else $error("tick longer than one cycle");
  cover property (MULT_ENABLED_O && SYS_CLK_KHZ_O == 20'h07D00);
  cover property (SYS_SRC_O == PCD_SRC_INTERNAL);
  cover property (CPU_TICK_O && CFG_LOW_I[4:3] == 2'h3);
endmodule
bind pcd_top pcd_top_chk pcd_top_chk_inst (.MCLK_I, .SRST_I, .CFG_HIGH_I, .CFG_LOW_I,
  .S_AXI_AWVALID, .S_AXI_WVALID, .S_AXI_ARVALID, .S_AXI_BREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_RVALID, .MULT_ENABLED_O, .SYS_SRC_O, .SYS_CLK_KHZ_O,
  .CPU_CLK_KHZ_O, .CPU_TICK_O);

// ===== testbench/pcd_top_tb.sv
/*
  Self-checking bench for the clock control top.
  Assumes the checker is bound to pcd_top.
*/
`timescale 1ns/100ps
`include "pcd_defines.svh"
module pcd_top_tb;
  import pcd_pkg::*;
  logic MCLK_I = 1'b0, SRST_I = 1'b1, SRC_CLK_I = 1'b0;
  logic [7:0] CFG_HIGH_I = 8'h00, CFG_LOW_I = 8'h00;
  logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic MULT_ENABLED_O, CPU_CLK_O, CPU_TICK_O;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA, rd;
  pcd_src_t SYS_SRC_O;
  pcd_khz_t SYS_CLK_KHZ_O, CPU_CLK_KHZ_O;
  int n_errors = 0, checked = 0;
  logic [2:0] src_cnt = 3'h0;
  pcd_top pcd_top_inst (.MCLK_I, .SRST_I, .CFG_HIGH_I, .CFG_LOW_I, .SRC_CLK_I,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .MULT_ENABLED_O, .SYS_SRC_O, .SYS_CLK_KHZ_O,
    .CPU_CLK_KHZ_O, .CPU_CLK_O, .CPU_TICK_O);
  // ==========
  // Clocks: source kept slow so edge detection never misses
  always #(`PCD_CLK_PERIOD_NS / 2.0) MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    src_cnt <= src_cnt + 3'h1;
    if (src_cnt == 3'h7) SRC_CLK_I <= ~SRC_CLK_I;
  end
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge MCLK_I);
    CFG_HIGH_I <= hi;
    CFG_LOW_I <= lo;
    SRST_I <= 1'b1;
    repeat (20) @(posedge MCLK_I);
    SRST_I <= 1'b0;
    repeat (3) @(posedge MCLK_I);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge MCLK_I);
    S_AXI_AWADDR <= {24'h0, a};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do @(negedge MCLK_I); while (!(S_AXI_AWREADY && S_AXI_WREADY));
    @(posedge MCLK_I);
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID <= 1'b0;
    do @(negedge MCLK_I); while (!S_AXI_BVALID);
    check("bresp", {30'h0, S_AXI_BRESP}, {30'h0, er});
    @(posedge MCLK_I);
    S_AXI_BREADY <= 1'b0;
    repeat (3) @(negedge MCLK_I);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    @(posedge MCLK_I);
    S_AXI_ARADDR <= {24'h0, a};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(negedge MCLK_I); while (!S_AXI_ARREADY);
    @(posedge MCLK_I);
    S_AXI_ARVALID <= 1'b0;
    do @(negedge MCLK_I); while (!S_AXI_RVALID);
    rd = S_AXI_RDATA;
    check("rresp", {30'h0, S_AXI_RRESP}, {30'h0, er});
    @(posedge MCLK_I);
    S_AXI_RREADY <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic sc_enable();
    do_reset(8'h00, 8'h00);
    rdr(8'h40, 2'h2);
    check("unmapped", rd, 32'h0);
    wr(`PCD_OFF_STATUS, 32'h1, 2'h2);
    check("mult_off", {31'h0, MULT_ENABLED_O}, 32'h0);
    wr(`PCD_OFF_OSC_TUNE, 32'h40, 2'h0);
    check("mult_sw", {31'h0, MULT_ENABLED_O}, 32'h1);
    wr(`PCD_OFF_OSC_TUNE, 32'h0, 2'h0);
    check("mult_sw_off", {31'h0, MULT_ENABLED_O}, 32'h0);
    // Write with byte 0 masked must leave the enable alone
    @(posedge MCLK_I);
    S_AXI_WSTRB <= 4'h0;
    wr(`PCD_OFF_OSC_TUNE, 32'h40, 2'h0);
    check("strb_off", {31'h0, MULT_ENABLED_O}, 32'h0);
    @(posedge MCLK_I);
    S_AXI_WSTRB <= 4'hF;
    do_reset(8'h10, 8'h00);
    wr(`PCD_OFF_OSC_TUNE, 32'h0, 2'h0);
    rdr(`PCD_OFF_STATUS, 2'h0);
    check("mult_forced", {31'h0, rd[0]}, 32'h1);
  endtask
  task automatic sc_32mhz();
    for (int f = 8; f < 10; f++) begin
      do_reset({4'h0, 4'(f)}, 8'h00);
      wr(`PCD_OFF_OSC_CTRL, 32'h60, 2'h0);
      check("int_8m", {12'h0, SYS_CLK_KHZ_O}, 32'd8000);
      wr(`PCD_OFF_OSC_TUNE, 32'h40, 2'h0);
      check("int_32m", {12'h0, SYS_CLK_KHZ_O}, 32'd32000);
      rdr(`PCD_OFF_SYS_KHZ, 2'h0);
      check("sys_reg", rd, 32'h00007D00);
      check("src_pri", {30'h0, SYS_SRC_O}, {30'h0, PCD_SRC_PRIMARY});
      for (int s = 1; s < 4; s++) begin
        wr(`PCD_OFF_OSC_CTRL, 32'h60 | s, 2'h0);
        check("sel_khz", {12'h0, SYS_CLK_KHZ_O}, s == 1 ? 32'd32 : 32'd8000);
      end
    end
    // Plain 8 MHz direct write is refused while forced on, the select keeps its reset value
    do_reset(8'h10, 8'h00);
    wr(`PCD_OFF_OSC_CTRL, 32'h62, 2'h0);
    rdr(`PCD_OFF_OSC_CTRL, 2'h0);
    check("force_keep", rd, {25'h0, `PCD_INTERNAL_OSC_FREQ_SELECT_RESET, 4'h0});
  endtask
  task automatic sc_divider();
    int gap;
    for (int d = 0; d < 4; d++) begin
      do_reset(8'h00, {3'h0, 2'(d), 3'h0});
      wr(`PCD_OFF_OSC_CTRL, 32'h62, 2'h0);
      check("cpu_khz", {12'h0, CPU_CLK_KHZ_O}, 32'd12000 / (d + 1));
      rdr(`PCD_OFF_CPU_KHZ, 2'h0);
      check("cpu_reg", rd, 32'd12000 / (d + 1));
      rdr(`PCD_OFF_CONFIG, 2'h0);
      check("cfg_word", rd, {16'h0000, 3'h0, 2'(d), 3'h0, 8'h00});
      // Bench source period is 16 system cycles
      do @(negedge MCLK_I); while (!CPU_TICK_O);
      gap = 0;
      do begin
        @(negedge MCLK_I);
        gap++;
      end while (!CPU_TICK_O);
      check("tick_gap", gap, 16 * (d + 1));
      do @(negedge MCLK_I); while (CPU_CLK_O);
      do @(negedge MCLK_I); while (!CPU_CLK_O);
      gap = 0;
      do begin
        @(negedge MCLK_I);
        gap++;
      end while (CPU_CLK_O);
      do begin
        @(negedge MCLK_I);
        gap++;
      end while (!CPU_CLK_O);
      check("clk_period", gap, 16 * (d + 1));
    end
  endtask
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge MCLK_I);
    SRST_I <= 1'b0;
    sc_enable();
    sc_32mhz();
    sc_divider();
    report_and_stop();
  end
endmodule
